// ==== rtl/scfs_pkg.sv ====
/*
 * package for the serial clock format and start block: register offsets,
 * field positions, the control reset value and divider codes.
 * assumes nothing of its surroundings.
 */
package scfs_pkg;

   // register byte offsets on the software bus
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] DATA_OFF = 8'h08;

   // control register field positions
   localparam int CTRL_PHASE_BIT = 0;
   localparam int CTRL_POL_BIT = 1;
   localparam int CTRL_MASTER_BIT = 2;
   localparam int CTRL_ENABLE_BIT = 3;
   localparam int CTRL_RATE_LSB = 4;
   localparam int CTRL_WIDTH = 6;
   localparam logic [5:0] CTRL_RESET = 6'h05;

   // status register field positions
   localparam int STAT_TXE_BIT = 0;
   localparam int STAT_RXF_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;

   // frame length and divider select codes
   localparam int FRAME_BITS = 8;
   localparam logic [1:0] RATE_DIVIDE_BY_TWO = 2'h0;
   localparam logic [1:0] RATE_DIVIDE_BY_EIGHT = 2'h1;
   localparam logic [1:0] RATE_DIVIDE_BY_THIRTY_TWO = 2'h2;
   localparam logic [1:0] RATE_DIVIDE_BY_ONE_TWENTY_EIGHT = 2'h3;
   // half a serial bit in bus cycles, minus one
   localparam logic [5:0] HALF_DIVIDE_BY_TWO = 6'h00;
   localparam logic [5:0] HALF_DIVIDE_BY_EIGHT = 6'h03;
   localparam logic [5:0] HALF_DIVIDE_BY_THIRTY_TWO = 6'h0F;
   localparam logic [5:0] HALF_DIVIDE_BY_ONE_TWENTY_EIGHT = 6'h3F;

endpackage : scfs_pkg

// ==== rtl/scfs_link_if.sv ====
/*
 * serial link between the port and the far party: clock, two data lines
 * and select; clock and data pins split into in/out/enable, select a plain far-side level.
 * resolves the wires itself from the enables; the dev side wins over the far side.
 */
`timescale 1ns/1ps
interface scfs_link_if;
   logic sck_o_dev;
   logic sck_oe_dev;
   logic sck_o_far;
   logic sck_oe_far;
   logic mosi_o_dev;
   logic mosi_oe_dev;
   logic mosi_o_far;
   logic mosi_oe_far;
   logic miso_o_dev;
   logic miso_oe_dev;
   logic miso_o_far;
   logic miso_oe_far;
   logic ss_n_far;
   // resolved levels
   logic sck;
   logic mosi;
   logic miso;
   assign sck = sck_oe_dev ? sck_o_dev : (sck_oe_far ? sck_o_far : 1'b0);
   assign mosi = mosi_oe_dev ? mosi_o_dev : (mosi_oe_far ? mosi_o_far : 1'b0);
   assign miso = miso_oe_dev ? miso_o_dev : (miso_oe_far ? miso_o_far : 1'b0);

   modport dev (
      input sck, mosi, miso, ss_n_far,
      output sck_o_dev, sck_oe_dev, mosi_o_dev, mosi_oe_dev,
      output miso_o_dev, miso_oe_dev
   );
   modport far (
      input sck, mosi, miso,
      output sck_o_far, sck_oe_far, mosi_o_far, mosi_oe_far,
      output miso_o_far, miso_oe_far, ss_n_far
   );
endinterface : scfs_link_if

// ==== rtl/scfs_sync.sv ====
/*
 * two-flop synchroniser for one pin level.
 * assumes a single bus clock.
 */
`timescale 1ns/1ps
module scfs_sync (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // level in and out
   input wire logic din,
   output logic dout
);
   logic meta_ff;
   logic sync_ff;

   // first flop is read only by the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   assign dout = sync_ff;
endmodule : scfs_sync

// ==== rtl/scfs_port.sv ====
/*
 * serial port end: ahb-lite register slave, master clock generator,
 * master and slave shift engine for both phase formats.
 * assumes one bus clock and a far party that keeps the select rules.
 */
`timescale 1ns/1ps
module scfs_port (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial link
   scfs_link_if.dev link
);
   typedef struct packed {
      logic [5:0] ctrl;
      logic [7:0] txbuf;
      logic txfull;
      logic [7:0] shreg;
      logic [7:0] rxreg;
      logic rxfull;
      logic active;
      logic [3:0] edges;
      logic [5:0] divcnt;
      logic tick;
      logic sck;
      logic mosi;
      logic miso;
      logic sck_prev;
      logic ss_prev;
      logic inbit;
      logic dph;
      logic dwr;
      logic [7:0] daddr;
      logic [31:0] rdata;
   } scfs_port_s;

   scfs_port_s st_ff;
   scfs_port_s nxt_st;
   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic ss_s;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   scfs_sync u_sync_sck (.hclk(hclk), .hresetn(hresetn),
      .din(link.sck), .dout(sck_s));
   scfs_sync u_sync_mosi (.hclk(hclk), .hresetn(hresetn),
      .din(link.mosi), .dout(mosi_s));
   scfs_sync u_sync_miso (.hclk(hclk), .hresetn(hresetn),
      .din(link.miso), .dout(miso_s));
   scfs_sync u_sync_ss (.hclk(hclk), .hresetn(hresetn),
      .din(link.ss_n_far), .dout(ss_s));

   logic phase;
   logic pol;
   logic master;
   logic enable;
   logic [1:0] rate;
   logic [5:0] half;
   assign phase = st_ff.ctrl[scfs_pkg::CTRL_PHASE_BIT];
   assign pol = st_ff.ctrl[scfs_pkg::CTRL_POL_BIT];
   assign master = st_ff.ctrl[scfs_pkg::CTRL_MASTER_BIT];
   assign enable = st_ff.ctrl[scfs_pkg::CTRL_ENABLE_BIT];
   assign rate = st_ff.ctrl[scfs_pkg::CTRL_RATE_LSB +: 2];

   // half bit period per divider code
   always_comb begin
      case (rate)
         scfs_pkg::RATE_DIVIDE_BY_TWO: half = scfs_pkg::HALF_DIVIDE_BY_TWO;
         scfs_pkg::RATE_DIVIDE_BY_EIGHT: half = scfs_pkg::HALF_DIVIDE_BY_EIGHT;
         scfs_pkg::RATE_DIVIDE_BY_THIRTY_TWO: half = scfs_pkg::HALF_DIVIDE_BY_THIRTY_TWO;
         default: half = scfs_pkg::HALF_DIVIDE_BY_ONE_TWENTY_EIGHT;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // next state: bus slave, clock divider, shift engine
   always_comb begin
      logic wr_data;
      logic lead;
      logic trail;
      logic slv_lead;
      logic slv_trail;
      logic ss_fall;
      logic sel;
      logic capture;
      logic launch;
      wr_data = 1'b0;
      lead = 1'b0;
      trail = 1'b0;
      slv_lead = 1'b0;
      slv_trail = 1'b0;
      ss_fall = 1'b0;
      sel = 1'b0;
      capture = 1'b0;
      launch = 1'b0;
      nxt_st = st_ff;
      nxt_st.sck_prev = sck_s;
      nxt_st.ss_prev = ss_s;
      nxt_st.tick = 1'b0;

      // bus address phase; slave is zero-wait
      nxt_st.dph = hsel && hready && htrans[1];
      if (hsel && hready && htrans[1]) begin
         nxt_st.dwr = hwrite;
         nxt_st.daddr = haddr[7:0];
      end
      nxt_st.rdata = 32'h0;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            scfs_pkg::CTRL_OFF: nxt_st.rdata = {26'h0, st_ff.ctrl};
            scfs_pkg::STAT_OFF: begin
               nxt_st.rdata[scfs_pkg::STAT_TXE_BIT] = !st_ff.txfull;
               nxt_st.rdata[scfs_pkg::STAT_RXF_BIT] = st_ff.rxfull;
               nxt_st.rdata[scfs_pkg::STAT_BUSY_BIT] = st_ff.active;
            end
            scfs_pkg::DATA_OFF: begin
               nxt_st.rdata = {24'h0, st_ff.rxreg};
               nxt_st.rxfull = 1'b0;
            end
            default: nxt_st.rdata = 32'h0;
         endcase
      end
      if (st_ff.dph && st_ff.dwr) begin
         case (st_ff.daddr)
            scfs_pkg::CTRL_OFF: nxt_st.ctrl = hwdata[5:0];
            scfs_pkg::DATA_OFF: wr_data = 1'b1;
            default: wr_data = 1'b0;
         endcase
      end

      // free-running divider, tick each half bit
      if (enable && master) begin
         if (st_ff.divcnt >= half) begin
            nxt_st.divcnt = 6'h00;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.divcnt = st_ff.divcnt + 6'h01;
         end
      end else begin
         nxt_st.divcnt = 6'h00;
      end

      // write lands in buffer, clears empty flag
      if (wr_data) begin
         nxt_st.txbuf = hwdata[7:0];
         nxt_st.txfull = 1'b1;
      end

      sel = !ss_s;
      ss_fall = st_ff.ss_prev && !ss_s;
      slv_lead = (st_ff.sck_prev == pol) && (sck_s != pol);
      slv_trail = (st_ff.sck_prev != pol) && (sck_s == pol);

      if (!enable) begin
         nxt_st.active = 1'b0;
         nxt_st.edges = 4'h0;
         nxt_st.sck = pol;
      end else if (master) begin
         // master: start at a tick so delay is at most a bit time
         if (!st_ff.active) begin
            nxt_st.sck = pol;
            if (st_ff.txfull && st_ff.tick) begin
               nxt_st.shreg = st_ff.txbuf;
               nxt_st.txfull = wr_data;
               nxt_st.active = 1'b1;
               nxt_st.edges = 4'h0;
               nxt_st.mosi = st_ff.txbuf[7];
               if (phase) begin
                  nxt_st.sck = !pol;
                  nxt_st.edges = 4'h1;
               end
            end
         end else if (st_ff.tick) begin
            nxt_st.edges = st_ff.edges + 4'h1;
            nxt_st.sck = !st_ff.sck;
            lead = (st_ff.sck == pol);
            trail = !lead;
            capture = phase ? trail : lead;
            launch = phase ? lead : trail;
            if (st_ff.edges == 4'hF) begin
               nxt_st.active = 1'b0;
               nxt_st.sck = pol;
            end
         end
         if (capture) begin
            nxt_st.inbit = miso_s;
         end
         if (launch && st_ff.edges != 4'h0) begin
            nxt_st.shreg = {st_ff.shreg[6:0], st_ff.inbit};
            nxt_st.mosi = st_ff.shreg[6];
         end
      end else begin
         // slave: start on select fall or first edge
         if (!st_ff.active) begin
            if ((!phase && ss_fall) || (phase && sel && slv_lead)) begin
               nxt_st.active = 1'b1;
               nxt_st.edges = phase ? 4'h1 : 4'h0;
               if (st_ff.txfull) begin
                  nxt_st.shreg = st_ff.txbuf;
                  nxt_st.txfull = wr_data;
                  nxt_st.miso = st_ff.txbuf[7];
               end else begin
                  nxt_st.miso = st_ff.shreg[7];
               end
            end else if (st_ff.txfull) begin
               nxt_st.shreg = st_ff.txbuf;
               nxt_st.txfull = wr_data;
            end
         end else if (slv_lead || slv_trail) begin
            // buffer held while active
            nxt_st.edges = st_ff.edges + 4'h1;
            capture = phase ? slv_trail : slv_lead;
            launch = phase ? slv_lead : slv_trail;
            if (st_ff.edges == 4'hF) begin
               nxt_st.active = 1'b0;
            end
         end
         if (capture) begin
            nxt_st.inbit = mosi_s;
         end
         if (launch && st_ff.edges != 4'h0) begin
            nxt_st.shreg = {st_ff.shreg[6:0], st_ff.inbit};
            nxt_st.miso = st_ff.shreg[6];
         end
      end

      // final capture completes the byte
      if (st_ff.active && capture && st_ff.edges == 4'hE + {3'h0, phase}) begin
         nxt_st.rxreg = {st_ff.shreg[6:0], master ? miso_s : mosi_s};
         nxt_st.rxfull = 1'b1; // set wins over read clear
         nxt_st.shreg = {st_ff.shreg[6:0], master ? miso_s : mosi_s};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
         st_ff.ctrl <= scfs_pkg::CTRL_RESET;
         // matches the synchroniser's reset level, so no false select fall
         st_ff.ss_prev <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // bus answers and pin drivers
   assign hrdata = st_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign link.sck_o_dev = st_ff.sck;
   assign link.sck_oe_dev = enable && master;
   assign link.mosi_o_dev = st_ff.mosi;
   assign link.mosi_oe_dev = enable && master;
   assign link.miso_o_dev = st_ff.miso;
   assign link.miso_oe_dev = enable && !master && !ss_s;
endmodule : scfs_port

// ==== rtl/scfs_far.sv ====
/*
 * far party: a plain master that frames bytes with select and clock.
 * assumes one bus clock; its clock is divided from hclk.
 */
`timescale 1ns/1ps
module scfs_far (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // user side
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic cfg_phase,
   input wire logic cfg_pol,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   // serial link
   scfs_link_if.far link
);
   typedef enum logic [1:0] {IDLE, SETUP, SHIFT, GAP} scfs_far_e;
   typedef struct packed {
      scfs_far_e state;
      logic [7:0] sh;
      logic [3:0] edges;
      logic [2:0] cnt;
      logic sck;
      logic ss_n;
      logic done;
      logic [7:0] rx;
   } scfs_far_s;
   scfs_far_s st_ff;
   scfs_far_s nxt_st;
   logic miso_s;

   scfs_sync u_sync_miso (.hclk(hclk), .hresetn(hresetn),
      .din(link.miso), .dout(miso_s));

   // master sequencing; select toggles each byte
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.cnt = st_ff.cnt + 3'h1;
      case (st_ff.state)
         IDLE: begin
            nxt_st.sck = cfg_pol;
            if (start) begin
               nxt_st.sh = tx_byte;
               nxt_st.ss_n = 1'b0;
               nxt_st.edges = 4'h0;
               nxt_st.cnt = 3'h0;
               nxt_st.state = SETUP;
            end
         end
         SETUP: if (st_ff.cnt == 3'h7) begin
            nxt_st.state = SHIFT;
         end
         SHIFT: if (st_ff.cnt == 3'h7) begin
            nxt_st.sck = !st_ff.sck;
            nxt_st.edges = st_ff.edges + 4'h1;
            if ((st_ff.sck == cfg_pol) != cfg_phase) begin
               nxt_st.rx = {st_ff.rx[6:0], miso_s};
            end else if (st_ff.edges != 4'h0 || !cfg_phase) begin
               nxt_st.sh = {st_ff.sh[6:0], 1'b0};
            end
            if (st_ff.edges == 4'hF) begin
               nxt_st.state = GAP;
            end
         end
         GAP: if (st_ff.cnt == 3'h7) begin
            nxt_st.ss_n = 1'b1;
            nxt_st.done = 1'b1;
            nxt_st.state = IDLE;
         end
         default: nxt_st.state = IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
         st_ff.ss_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = st_ff.state != IDLE;
   assign done = st_ff.done;
   assign rx_byte = st_ff.rx;
   assign link.sck_o_far = st_ff.sck;
   assign link.sck_oe_far = 1'b1;
   assign link.mosi_o_far = st_ff.sh[7];
   assign link.mosi_oe_far = st_ff.state != IDLE;
   assign link.miso_o_far = 1'b0;
   assign link.miso_oe_far = 1'b0;
   assign link.ss_n_far = st_ff.ss_n;
endmodule : scfs_far

// ==== dv/scfs_link_assertions.sv ====
/*
 * checker for the serial link that joins the port and the far end.
 * assumes one bus clock and the link signals handed in as plain inputs.
 */
`timescale 1ns/1ps
module scfs_link_assertions (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link signals
   input wire logic sck_o_dev,
   input wire logic sck_oe_dev,
   input wire logic mosi_oe_dev,
   input wire logic miso_oe_dev,
   input wire logic sck_o_far,
   input wire logic ss_n_far
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////
   // port side: who owns which pin
   chk_miso_sel_only: assert property (
      ss_n_far [*4] |-> !miso_oe_dev)
      else $error("miso driven while deselected");
   chk_mode_exclusive: assert property (
      !(miso_oe_dev && sck_oe_dev))
      else $error("master and slave drivers both on");
   chk_mosi_sck_pair: assert property (
      mosi_oe_dev == sck_oe_dev)
      else $error("mosi and clock drivers disagree");
   // no driver may be on in the first cycle after reset is released
   chk_oe_after_reset: assert property (
      $rose(hresetn) |-> !sck_oe_dev && !mosi_oe_dev && !miso_oe_dev)
      else $error("driver on straight after reset");

   ////////////////////////////////////////////////////////////////
   // far side framing, seen by the port as its master
   chk_setup_before_edge: assert property (
      $fell(ss_n_far) |-> $stable(sck_o_far) [*4])
      else $error("clock moved right after select fell");
   chk_select_holds: assert property (
      $fell(ss_n_far) |-> !ss_n_far [*8])
      else $error("select released too early");
   chk_select_gap: assert property (
      $rose(ss_n_far) |-> ss_n_far [*2])
      else $error("select high too briefly");
   chk_edge_spacing: assert property (
      $changed(sck_o_far) |=> $stable(sck_o_far) [*4])
      else $error("far clock edges too close");

   // main scenarios
   cov_frame: cover property ($fell(ss_n_far));
   cov_master_edge: cover property (sck_oe_dev && $changed(sck_o_dev));
   cov_slave_drive: cover property (miso_oe_dev);
endmodule : scfs_link_assertions

// ==== dv/scfs_tb.sv ====
/*
 * testbench: port as master on the wire, then as slave of the far end.
 * assumes the link interface resolves pins and hreadyout feeds hready.
 */
`timescale 1ns/1ps
module scfs_tb;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic start;
   logic [7:0] tx_byte;
   logic cfg_phase;
   logic cfg_pol;
   logic busy;
   logic done;
   logic [7:0] rx_byte;
   logic [31:0] rd;
   int mismatches;
   int checked;
   int seed;

   scfs_link_if link ();
   scfs_port i_scfs_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(link.dev));
   scfs_far i_scfs_far (.hclk(hclk), .hresetn(hresetn), .start(start),
      .tx_byte(tx_byte), .cfg_phase(cfg_phase), .cfg_pol(cfg_pol),
      .busy(busy), .done(done), .rx_byte(rx_byte), .link(link.far));
   scfs_link_assertions i_scfs_link_assertions (.hclk(hclk),
      .hresetn(hresetn), .sck_o_dev(link.sck_o_dev),
      .sck_oe_dev(link.sck_oe_dev), .mosi_oe_dev(link.mosi_oe_dev),
      .miso_oe_dev(link.miso_oe_dev), .sck_o_far(link.sck_o_far),
      .ss_n_far(link.ss_n_far));

   ////////////////////////////////////////////////////////////////
   // checking and closing
   task automatic check(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : check

   task automatic print_verdict;
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // one bus cycle of a bounded wait; a spent bound ends the run
   task automatic step(inout int n, input int lim);
      @(posedge hclk);
      n++;
      if (n > lim) begin
         check(1'b0, "wait limit spent");
         print_verdict();
      end
   endtask : step

   // single word transfer; waits on hready in both phases
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do step(n, 64); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do step(n, 64); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(hresp === 1'b0, "bus response");
   endtask : ahb

   // format is only touched with the port disabled
   task automatic setup(input logic m, input logic p, input logic h,
                        input logic [1:0] r);
      ahb(1'b1, scfs_pkg::CTRL_OFF, {26'h0, r, 1'b0, m, p, h});
      ahb(1'b1, scfs_pkg::CTRL_OFF, {26'h0, r, 1'b1, m, p, h});
      ahb(1'b0, scfs_pkg::CTRL_OFF, 32'h0);
      check(rd[5:0] === {r, 1'b1, m, p, h}, "control readback");
   endtask : setup

   // wait for receive full, then fetch the byte
   task automatic fetch(input logic [7:0] exp);
      int n;
      n = 0;
      do begin
         ahb(1'b0, scfs_pkg::STAT_OFF, 32'h0);
         n++;
         if (n > 400) begin
            check(1'b0, "receive full never set");
            print_verdict();
         end
      end while (rd[scfs_pkg::STAT_RXF_BIT] !== 1'b1);
      check(rd[scfs_pkg::STAT_RXF_BIT] === 1'b1, "receive full");
      ahb(1'b0, scfs_pkg::DATA_OFF, 32'h0);
      check(rd[7:0] === exp, "received byte");
   endtask : fetch

   ////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   initial begin
      int n;
      int e;
      int half;
      logic [7:0] b;
      logic [7:0] got;
      logic last;
      logic [7:0] q [$];
      seed = 72;
      mismatches = 0;
      checked = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      start = 1'b0;
      tx_byte = 8'h00;
      cfg_phase = 1'b0;
      cfg_pol = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, scfs_pkg::CTRL_OFF, 32'h0);
      check(rd[5:0] === scfs_pkg::CTRL_RESET, "control reset value");
      ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
      ahb(1'b0, 8'h0C, 32'h0);
      check(rd === 32'h0, "unmapped read");
      // master: every format, every divider; watch clock and mosi
      for (int m = 0; m < 4; m++) begin
         half = 1 << (2 * m);
         b = $random(seed);
         // the port has no select input of its own as master
         setup(1'b1, m[1], m[0], m[1:0]);
         repeat (2) @(posedge hclk);
         check(link.sck === m[1], "master idle level");
         ahb(1'b1, scfs_pkg::DATA_OFF, {24'h0, b});
         n = 0;
         e = 0;
         last = m[1];
         got = 8'h00;
         while (e < 16) begin
            step(n, 40 * half + 8);
            #1;
            if (link.sck !== last) begin
               e++;
               last = link.sck;
               if (e == 1) begin
                  check(n <= 2 * half + (m[0] ? 0 : half) + 2,
                        "start delay");
               end
               if ((e % 2) != m[0]) begin
                  got = {got[6:0], link.mosi};
               end
            end
         end
         @(posedge hclk);
         check(got === b, "master shifted byte");
         fetch(8'h00);
      end
      // slave: far end frames bytes; second byte written mid-frame
      for (int m = 0; m < 4; m++) begin
         ahb(1'b1, scfs_pkg::CTRL_OFF, 32'h0);
         cfg_phase <= m[0];
         cfg_pol <= m[1];
         repeat (16) @(posedge hclk);
         setup(1'b0, m[1], m[0], 2'h0);
         check(link.miso_oe_dev === 1'b0, "miso while deselected");
         b = $random(seed);
         ahb(1'b1, scfs_pkg::DATA_OFF, {24'h0, b});
         q.push_back(b);
         for (int k = 0; k < 2; k++) begin
            got = $random(seed);
            tx_byte <= got;
            start <= 1'b1;
            @(posedge hclk);
            start <= 1'b0;
            if (k == 0) begin
               repeat (30) @(posedge hclk);
               b = $random(seed);
               ahb(1'b1, scfs_pkg::DATA_OFF, {24'h0, b});
               q.push_back(b);
               // frame still running: byte must wait in the buffer
               ahb(1'b0, scfs_pkg::STAT_OFF, 32'h0);
               check(rd[scfs_pkg::STAT_TXE_BIT] === 1'b0, "held");
               check(rd[scfs_pkg::STAT_BUSY_BIT] === 1'b1, "busy");
            end
            n = 0;
            do step(n, 400); while (done !== 1'b1);
            check(rx_byte === q.pop_front(), "slave sent byte");
            fetch(got);
            // frame over: buffer has moved into the shifter
            ahb(1'b0, scfs_pkg::STAT_OFF, 32'h0);
            check(rd[scfs_pkg::STAT_TXE_BIT] === 1'b1, "loaded");
            check(rd[scfs_pkg::STAT_BUSY_BIT] === 1'b0, "idle");
         end
      end
      print_verdict();
   end
endmodule : scfs_tb
